//--- tcr_timer.sv
// Sixteen-bit timer/counter with capture, auto-reload and baud generation.
// Assumes an 8-bit register port with one-cycle strobes and read data one cycle later,
// and an external trigger pin synchronous to sys_clk.
`timescale 1ns/1ps
module tcr_timer (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // External trigger pin
    input  wire logic       ext_trigger_pin,
    // Serial port timing base and interrupt
    output logic            baud_tick,
    output logic            irq
);
    tcr_pkg::tcr_req_t req;
    logic [7:0]  ctrl;
    logic [7:0]  mode;
    logic [7:0]  clock_control_reg;
    logic [15:0] cnt;
    logic [15:0] rcap;
    logic [1:0]  irq_st;
    logic [1:0]  irq_en;
    logic        int_tick;
    logic        pin_fall;
    logic        baud_mode;
    logic        step;
    logic        down;
    logic        ovf;
    logic        ext_evt;
    logic        do_capture;
    logic        do_reload;
    logic        hw_set_ovf;
    logic        hw_set_ext;
    logic [15:0] next_cnt;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Write decode shared by all register processes
    function automatic logic wr_hit(input tcr_pkg::tcr_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Tick sources
    tcr_tick u_tick (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .fast    (clock_control_reg[tcr_pkg::TCR_B_SPEED]),
        .tick    (int_tick)
    );

    tcr_fall u_fall (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .pin     (ext_trigger_pin),
        .fall    (pin_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode
    assign baud_mode = ctrl[tcr_pkg::TCR_B_RXBAUD] | ctrl[tcr_pkg::TCR_B_TXBAUD];
    // Baud mode ignores the select bit and times from internal ticks
    assign step = ctrl[tcr_pkg::TCR_B_RUN] &
                  ((baud_mode | ~ctrl[tcr_pkg::TCR_B_CTSEL]) ? int_tick
                                                              : pin_fall);
    // Down counting only in plain auto-reload mode
    assign down = mode[tcr_pkg::TCR_B_DOWN_COUNT_ENABLE] & ~ctrl[tcr_pkg::TCR_B_CPRL] & ~baud_mode;
    assign ovf  = step & (down ? (cnt == rcap) : (cnt == tcr_pkg::TCR_MAX16));
    // Trigger pin acts only outside baud mode; when counting edges it still fires
    assign ext_evt = ctrl[tcr_pkg::TCR_B_EXTEN] & ~baud_mode & pin_fall;
    assign do_capture = ~baud_mode & ctrl[tcr_pkg::TCR_B_CPRL] & ext_evt;
    // Overflow always reloads in baud mode; trigger reloads when bit clear and counting up
    assign do_reload  = baud_mode ? ovf
                      : (~ctrl[tcr_pkg::TCR_B_CPRL] & (ovf | (ext_evt & ~down)));
    assign hw_set_ovf = ovf & ~baud_mode;
    assign hw_set_ext = ext_evt;
    assign baud_tick  = ovf & baud_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Counter next value; hardware events take precedence over byte writes
    always_comb begin
        next_cnt = cnt;
        if (wr_hit(req, tcr_pkg::TCR_ADDR_CNT_LO)) begin
            next_cnt[7:0] = req.wdata;
        end
        if (wr_hit(req, tcr_pkg::TCR_ADDR_CNT_HI)) begin
            next_cnt[15:8] = req.wdata;
        end
        if (step && !ovf) begin
            next_cnt = down ? cnt - 16'h0001 : cnt + 16'h0001;
        end
        if (do_reload) begin
            // Down-count underflow wraps to all ones instead of the pair
            next_cnt = (down && ovf) ? tcr_pkg::TCR_MAX16 : rcap;
        end else if (ovf) begin
            next_cnt = tcr_pkg::TCR_RST16;
        end
        if (do_capture && mode[tcr_pkg::TCR_B_CLR]) begin
            next_cnt = tcr_pkg::TCR_RST16;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= tcr_pkg::TCR_RST16;
        end else begin
            cnt <= next_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reload/capture pair; capture stores both bytes in one cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rcap <= tcr_pkg::TCR_RST16;
        end else if (do_capture) begin
            rcap <= cnt;
        end else begin
            if (wr_hit(req, tcr_pkg::TCR_ADDR_RCAP_LO)) begin
                rcap[7:0] <= req.wdata;
            end
            if (wr_hit(req, tcr_pkg::TCR_ADDR_RCAP_HI)) begin
                rcap[15:8] <= req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register; hardware flag set wins over software clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= tcr_pkg::TCR_RST8;
        end else begin
            if (wr_hit(req, tcr_pkg::TCR_ADDR_CTRL)) begin
                ctrl <= req.wdata;
            end
            if (hw_set_ovf) begin
                ctrl[tcr_pkg::TCR_B_OVF] <= 1'b1;
            end
            if (hw_set_ext) begin
                ctrl[tcr_pkg::TCR_B_EXTF] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode and clock control registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode              <= tcr_pkg::TCR_RST8;
            clock_control_reg <= tcr_pkg::TCR_RST8;
        end else begin
            if (wr_hit(req, tcr_pkg::TCR_ADDR_MODE)) begin
                mode <= req.wdata & tcr_pkg::TCR_MODE_MASK;
            end
            if (wr_hit(req, tcr_pkg::TCR_ADDR_CLKCTL)) begin
                clock_control_reg <= req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status: sticky, set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_st <= 2'h0;
            irq_en <= 2'h0;
        end else begin
            if (wr_hit(req, tcr_pkg::TCR_ADDR_IRQ_EN)) begin
                irq_en <= req.wdata[1:0];
            end
            irq_st <= (irq_st & ~(wr_hit(req, tcr_pkg::TCR_ADDR_IRQ_CLR) ?
                                  req.wdata[1:0] : 2'h0))
                      | {hw_set_ext, hw_set_ovf};
        end
    end

    assign irq = |(irq_st & irq_en);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, registered; unmapped addresses read zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= tcr_pkg::TCR_RST8;
        end else if (req.rd) begin
            unique case (req.addr)
                tcr_pkg::TCR_ADDR_CTRL:    reg_rdata <= ctrl;
                tcr_pkg::TCR_ADDR_MODE:    reg_rdata <= mode;
                tcr_pkg::TCR_ADDR_RCAP_LO: reg_rdata <= rcap[7:0];
                tcr_pkg::TCR_ADDR_RCAP_HI: reg_rdata <= rcap[15:8];
                tcr_pkg::TCR_ADDR_CNT_LO:  reg_rdata <= cnt[7:0];
                tcr_pkg::TCR_ADDR_CNT_HI:  reg_rdata <= cnt[15:8];
                tcr_pkg::TCR_ADDR_CLKCTL:  reg_rdata <= clock_control_reg;
                tcr_pkg::TCR_ADDR_IRQ_ST:  reg_rdata <= {6'h00, irq_st};
                tcr_pkg::TCR_ADDR_IRQ_EN:  reg_rdata <= {6'h00, irq_en};
                default:                   reg_rdata <= tcr_pkg::TCR_RST8;
            endcase
        end else begin
            reg_rdata <= tcr_pkg::TCR_RST8;
        end
    end
endmodule

//--- tcr_pkg.sv
// Package for the sixteen-bit capture/reload timer: register map, fields, types.
// Assumes an 8-bit register port in the special function register space.
package tcr_pkg;
    // Register offsets of the timer in the special function space
    localparam logic [7:0] TCR_ADDR_CTRL    = 8'hc8;  // Own control register
    localparam logic [7:0] TCR_ADDR_MODE    = 8'hc9;
    localparam logic [7:0] TCR_ADDR_RCAP_LO = 8'hca;
    localparam logic [7:0] TCR_ADDR_RCAP_HI = 8'hcb;
    localparam logic [7:0] TCR_ADDR_CNT_LO  = 8'hcc;
    localparam logic [7:0] TCR_ADDR_CNT_HI  = 8'hcd;
    localparam logic [7:0] TCR_ADDR_CLKCTL  = 8'hc4;
    localparam logic [7:0] TCR_ADDR_IRQ_ST  = 8'hc5;
    localparam logic [7:0] TCR_ADDR_IRQ_EN  = 8'hc6;
    localparam logic [7:0] TCR_ADDR_IRQ_CLR = 8'hc7;

    // Control register bit positions
    localparam int TCR_B_OVF    = 7;
    localparam int TCR_B_EXTF   = 6;
    localparam int TCR_B_RXBAUD = 5;
    localparam int TCR_B_TXBAUD = 4;
    localparam int TCR_B_EXTEN  = 3;
    localparam int TCR_B_RUN    = 2;
    localparam int TCR_B_CTSEL  = 1;
    localparam int TCR_B_CPRL   = 0;
    // Mode register bit positions
    localparam int TCR_B_CLR    = 3;
    localparam int TCR_B_DOWN_COUNT_ENABLE   = 0;
    localparam logic [7:0] TCR_MODE_MASK = 8'h09;
    // Clock control bit position (speed select)
    localparam int TCR_B_SPEED  = 5;
    // Interrupt status bit positions
    localparam int TCR_I_OVF    = 0;
    localparam int TCR_I_EXT    = 1;

    // Tick prescale: slow tick every 12 clocks, fast every 4
    localparam logic [3:0] TCR_DIV_SLOW = 4'hb;
    localparam logic [3:0] TCR_DIV_FAST = 4'h3;

    localparam logic [7:0]  TCR_RST8  = 8'h00;
    localparam logic [15:0] TCR_RST16 = 16'h0000;
    localparam logic [15:0] TCR_MAX16 = 16'hffff;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tcr_req_t;
endpackage

//--- tcr_tick.sv
// Prescaler producing the internal count tick enable.
// Assumes one clock; speed select is a level from the clock control register.
`timescale 1ns/1ps
module tcr_tick (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // Control
    input  wire logic fast,
    // Tick out
    output logic      tick
);
    logic [3:0] div;

    ////////////////////////////////////////////////////////////////////////////
    // Divider; a speed switch moves the wrap point at once, and a div already past it runs on to 15
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            div <= 4'h0;
        end else if (div == (fast ? tcr_pkg::TCR_DIV_FAST : tcr_pkg::TCR_DIV_SLOW)) begin
            div <= 4'h0;
        end else begin
            div <= div + 4'h1;
        end
    end

    assign tick = (div == (fast ? tcr_pkg::TCR_DIV_FAST : tcr_pkg::TCR_DIV_SLOW));
endmodule

//--- tcr_fall.sv
// Falling edge detector for the external trigger pin.
// Assumes the pin is already synchronous to sys_clk.
`timescale 1ns/1ps
module tcr_fall (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // Pin
    input  wire logic pin,
    // One-cycle pulse on a high-to-low change
    output logic      fall
);
    logic prev;

    ////////////////////////////////////////////////////////////////////////////
    // Idle high so a high pin at reset release is no edge; a low pin gives one
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev <= 1'b1;
        end else begin
            prev <= pin;
        end
    end

    assign fall = prev & ~pin;
endmodule

//--- tcr_timer_checker.sv
// Port-level assertions for the capture/reload timer.
// Assumes it is bound to tcr_timer and sees only its ports.
`timescale 1ns/1ps
module tcr_timer_checker (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pin and outputs
    input wire logic       ext_trigger_pin,
    input wire logic       baud_tick,
    input wire logic       irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [3:0] ctl;
    logic [7:0] en;
    logic       pin_q;
    wire        baud = ctl[3] | ctl[2];
    wire        fall = pin_q & ~ext_trigger_pin;
    ////////////////////////////////////////////////////////////////////////
    // Shadows of software-only bits; hardware never moves them
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctl   <= 4'h0;
            en    <= 8'h00;
            pin_q <= 1'b1;  // Matches detector idle; a low pin at release is an edge
        end else begin
            pin_q <= ext_trigger_pin;
            if (reg_wr && reg_addr == tcr_pkg::TCR_ADDR_CTRL) ctl <= reg_wdata[5:2];
            if (reg_wr && reg_addr == tcr_pkg::TCR_ADDR_IRQ_EN) en <= reg_wdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_unmapped; $past(reg_rd) && $past(reg_addr) == 8'h00 |-> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_mode_mask;
        $past(reg_rd) && $past(reg_addr) == tcr_pkg::TCR_ADDR_MODE
            |-> (reg_rdata & ~tcr_pkg::TCR_MODE_MASK) == 8'h00;
    endproperty
    a_mode_mask: assert property (p_mode_mask) else $error("mode spare bits set");
    property p_ctl_rb;
        $past(reg_rd) && $past(reg_addr) == tcr_pkg::TCR_ADDR_CTRL
            |-> reg_rdata[5:2] == $past(ctl);
    endproperty
    a_ctl_rb: assert property (p_ctl_rb) else $error("control readback wrong");
    property p_baud_src; baud_tick |-> baud; endproperty
    a_baud_src: assert property (p_baud_src) else $error("baud tick outside baud mode");
    property p_baud_run; baud_tick |-> ctl[0]; endproperty
    a_baud_run: assert property (p_baud_run) else $error("baud tick while stopped");
    property p_baud_pulse; baud_tick |=> !baud_tick; endproperty
    a_baud_pulse: assert property (p_baud_pulse) else $error("baud tick too long");
    property p_irq_en; irq |-> en != 8'h00; endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq with nothing enabled");
    property p_ext_irq; fall && ctl[1] && !baud && en[1] |-> ##[1:2] irq; endproperty
    a_ext_irq: assert property (p_ext_irq) else $error("trigger edge gave no irq");
    c_baud: cover property (baud_tick);
    c_ext: cover property (fall && ctl[1]);
    c_irq: cover property ($rose(irq));
endmodule
bind tcr_timer tcr_timer_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_trigger_pin(ext_trigger_pin), .baud_tick(baud_tick), .irq(irq));

//--- tcr_far.sv
// Far side model: trigger pin source and serial baud consumer.
// Assumes one clock; the pin is driven synchronous to sys_clk.
`timescale 1ns/1ps
module tcr_far (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // Baud tick in
    input  wire logic       baud_tick,
    // Pin and measured tick spacing
    output logic            ext_trigger_pin,
    output logic      [7:0] gap
);
    logic [7:0] cnt;
    initial ext_trigger_pin = 1'b1;
    // Clocks between baud ticks, as a serial port would see its rate
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 8'h00;
            gap <= 8'h00;
        end else if (baud_tick) begin
            gap <= cnt + 8'h01;
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
    // One falling edge; low and high two cycles each, above the minimum
    task automatic fall();
        @(posedge sys_clk);
        ext_trigger_pin <= 1'b0;
        repeat (2) @(posedge sys_clk);
        ext_trigger_pin <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask
endmodule

//--- testbench.sv
// Self-checking bench for the capture/reload timer.
// Assumes tcr_pkg, tcr_timer and tcr_far are compiled first.
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [7:0] a, w, r0, r1;} tcr_row_t;
    logic       sys_clk, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, gap;
    logic       ext_trigger_pin, baud_tick, irq;
    int         fails = 0, checks = 0, cyc = 0;
    // Address, write value, reset value, value read back
    tcr_row_t   rows [9] = '{'{tcr_pkg::TCR_ADDR_MODE, 8'hff, 8'h00, 8'h09},
        '{tcr_pkg::TCR_ADDR_RCAP_LO, 8'h5a, 8'h00, 8'h5a},
        '{tcr_pkg::TCR_ADDR_RCAP_HI, 8'ha5, 8'h00, 8'ha5},
        '{tcr_pkg::TCR_ADDR_CNT_LO, 8'h34, 8'h00, 8'h34},
        '{tcr_pkg::TCR_ADDR_CNT_HI, 8'h12, 8'h00, 8'h12},
        '{tcr_pkg::TCR_ADDR_IRQ_EN, 8'h03, 8'h00, 8'h03},
        '{tcr_pkg::TCR_ADDR_IRQ_ST, 8'hff, 8'h00, 8'h00},
        '{8'h00, 8'hff, 8'h00, 8'h00},
        '{tcr_pkg::TCR_ADDR_CTRL, 8'h00, 8'h00, 8'h00}};
    tcr_timer dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_trigger_pin(ext_trigger_pin), .baud_tick(baud_tick), .irq(irq));
    tcr_far far (.sys_clk(sys_clk), .nrst(nrst), .baud_tick(baud_tick),
        .ext_trigger_pin(ext_trigger_pin), .gap(gap));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // One-cycle write strobe; the gap edge keeps strobes from double assignment
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk(reg_rdata, e);
    endtask
    task automatic ci(input logic e);
        @(negedge sys_clk);
        chk({7'h00, irq}, {7'h00, e});
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Run needs under 2000 cycles; a hang counts as a mismatch
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].a, rows[i].r0);
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r1);
        end
        // Fast timer overflow sets the flag, then baud mode reloads
        wr(tcr_pkg::TCR_ADDR_MODE, 8'h00);
        wr(tcr_pkg::TCR_ADDR_CLKCTL, 8'h20);
        wr(tcr_pkg::TCR_ADDR_RCAP_LO, 8'hfe);
        wr(tcr_pkg::TCR_ADDR_RCAP_HI, 8'hff);
        wr(tcr_pkg::TCR_ADDR_CNT_LO, 8'hfe);
        wr(tcr_pkg::TCR_ADDR_CNT_HI, 8'hff);
        wr(tcr_pkg::TCR_ADDR_CTRL, 8'h04);
        repeat (40) @(posedge sys_clk);
        ci(1'b1);
        rd(tcr_pkg::TCR_ADDR_CTRL, 8'h84);
        wr(tcr_pkg::TCR_ADDR_CTRL, 8'h00);
        wr(tcr_pkg::TCR_ADDR_CTRL, 8'h24);
        repeat (60) @(posedge sys_clk);
        chk(gap, 8'h08);
        wr(tcr_pkg::TCR_ADDR_CTRL, 8'h17);
        repeat (60) @(posedge sys_clk);
        chk(gap, 8'h08);
        rd(tcr_pkg::TCR_ADDR_CTRL, 8'h17);
        wr(tcr_pkg::TCR_ADDR_CLKCTL, 8'h00);
        repeat (100) @(posedge sys_clk);
        chk(gap, 8'h18);
        // Trigger capture while stopped, masking and clearing the interrupt
        wr(tcr_pkg::TCR_ADDR_CTRL, 8'h00);
        wr(tcr_pkg::TCR_ADDR_CNT_LO, 8'h34);
        wr(tcr_pkg::TCR_ADDR_CNT_HI, 8'h12);
        wr(tcr_pkg::TCR_ADDR_IRQ_CLR, 8'h03);
        wr(tcr_pkg::TCR_ADDR_CTRL, 8'h09);
        far.fall();
        ci(1'b1);
        rd(tcr_pkg::TCR_ADDR_RCAP_LO, 8'h34);
        rd(tcr_pkg::TCR_ADDR_RCAP_HI, 8'h12);
        rd(tcr_pkg::TCR_ADDR_CNT_LO, 8'h34);
        wr(tcr_pkg::TCR_ADDR_IRQ_EN, 8'h00);
        ci(1'b0);
        wr(tcr_pkg::TCR_ADDR_IRQ_EN, 8'h03);
        ci(1'b1);
        wr(tcr_pkg::TCR_ADDR_IRQ_CLR, 8'h03);
        ci(1'b0);
        // Capture with auto-clear, then a trigger that must be ignored
        wr(tcr_pkg::TCR_ADDR_MODE, 8'h08);
        wr(tcr_pkg::TCR_ADDR_CNT_LO, 8'hab);
        wr(tcr_pkg::TCR_ADDR_CNT_HI, 8'h00);
        far.fall();
        rd(tcr_pkg::TCR_ADDR_RCAP_LO, 8'hab);
        rd(tcr_pkg::TCR_ADDR_CNT_LO, 8'h00);
        wr(tcr_pkg::TCR_ADDR_CTRL, 8'h01);
        wr(tcr_pkg::TCR_ADDR_CNT_LO, 8'h77);
        far.fall();
        rd(tcr_pkg::TCR_ADDR_RCAP_LO, 8'hab);
        // Pin edges as count source, up then down
        wr(tcr_pkg::TCR_ADDR_MODE, 8'h00);
        wr(tcr_pkg::TCR_ADDR_CTRL, 8'h06);
        repeat (3) far.fall();
        wr(tcr_pkg::TCR_ADDR_CTRL, 8'h00);
        rd(tcr_pkg::TCR_ADDR_CNT_LO, 8'h7a);
        wr(tcr_pkg::TCR_ADDR_MODE, 8'h01);
        wr(tcr_pkg::TCR_ADDR_CTRL, 8'h06);
        far.fall();
        wr(tcr_pkg::TCR_ADDR_CTRL, 8'h00);
        rd(tcr_pkg::TCR_ADDR_CNT_LO, 8'h79);
        // Trigger edge in reload mode loads the pair into the stopped counter
        wr(tcr_pkg::TCR_ADDR_MODE, 8'h00);
        wr(tcr_pkg::TCR_ADDR_CTRL, 8'h08);
        far.fall();
        ci(1'b1);
        rd(tcr_pkg::TCR_ADDR_CNT_LO, 8'hab);
        rd(tcr_pkg::TCR_ADDR_CNT_HI, 8'h00);
        // Reset with the counter stopped drops the interrupt and clears the counter, pair and control registers
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        ci(1'b0);
        @(posedge sys_clk);
        nrst <= 1'b1;
        rd(tcr_pkg::TCR_ADDR_CNT_LO, 8'h00);
        rd(tcr_pkg::TCR_ADDR_RCAP_LO, 8'h00);
        rd(tcr_pkg::TCR_ADDR_CTRL, 8'h00);
        print_verdict();
    end
endmodule
